// ---- design/battery_backup_switch_control.sv ----
/*
 * Battery backup switchover control: mode sequencing, switch control,
 * detector scheduling, battery flags and bus/clock-output gating.
 * Assumes comparators and pads outside; control writes come from the
 * bus slave on ref_clk and are only honoured while the bus is enabled.
 */
`timescale 1ns/100ps
module battery_backup_switch_control
	import battery_switch_pkg::*;
#(
	parameter int OFF_2MS_CYC     = T_OFF_2MS_NS / CLK_PERIOD_NS,
	parameter int OFF_16MS_CYC    = T_OFF_16MS_NS / CLK_PERIOD_NS,
	parameter int OFF_128MS_CYC   = T_OFF_128MS_NS / CLK_PERIOD_NS,
	parameter int OFF_256MS_CYC   = T_OFF_256MS_NS / CLK_PERIOD_NS,
	parameter int BACKUP_POLL_CYC = T_BACKUP_POLL_NS / CLK_PERIOD_NS,
	parameter int BAT_POLL_CYC    = T_BAT_POLL_NS / CLK_PERIOD_NS
)(
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire det_s       det_async,
	input  wire logic       ctrl_wr,
	input  wire ctrl_s      ctrl_wdata,
	input  wire logic       low_flag_wr,
	input  wire logic       low_flag_wdata,
	output ctrl_s           ctrl_q,
	output logic            battery_full_flag,
	output logic            battery_low_flag,
	output logic            i2c_enable,
	output logic            clock_output_enable,
	output logic            supply_switch_on,
	output logic            charge_switch_on,
	output logic            backup_mode,
	output logic            reset_detect_enable,
	output logic            supply_detect_enable,
	output logic            battery_detect_enable,
	output logic [1:0]      full_level_code
);

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	det_s             det_meta;
	det_s             det;
	mode_e            state;
	mode_e            next_state;
	logic             gate_ever_set;
	logic             returned;
	logic             bat_low_now;
	logic             charge_active;
	logic             charging;
	logic             low_allowed;
	logic             sample_done;
	logic             per_load;
	logic [CNT_W-1:0] per_value;
	logic [CNT_W-1:0] per_count;
	logic             per_exp;
	logic             per_idle;
	logic             win_load;
	logic [CNT_W-1:0] win_value;
	logic [CNT_W-1:0] win_count;
	logic             win_exp;
	logic             next_backup;

	function automatic logic [CNT_W-1:0] off_time(
		input logic [1:0] sel,
		input logic       after_return
	);
		logic [CNT_W-1:0] t;
		t = CNT_W'(OFF_2MS_CYC);
		if (!after_return)
		begin
			case (sel)
				SMP_16MS:  t = CNT_W'(OFF_16MS_CYC);
				SMP_128MS: t = CNT_W'(OFF_128MS_CYC);
				SMP_256MS: t = CNT_W'(OFF_256MS_CYC);
				default:   t = CNT_W'(OFF_2MS_CYC);
			endcase
		end
		return t;
	endfunction

	// Two-stage synchroniser per comparator bit
	genvar gi;
	generate
		for (gi = 0; gi < DET_W; gi++)
		begin : g_sync
			always_ff @(posedge ref_clk)
			begin
				if (rst)
				begin
					det_meta[gi] <= 1'b0;
					det[gi]      <= 1'b0;
				end
				else
				begin
					det_meta[gi] <= det_async[gi];
					det[gi]      <= det_meta[gi];
				end
			end
		end
	endgenerate

	// Bus gating; writes are refused while the bus is off
	assign backup_mode = (state == ST_BACKUP) ||
		(state == ST_BACKUP_CHECK);
	assign i2c_enable = !backup_mode &&
		!(ctrl_q.interface_gate_enable && det.below_reset);
	assign clock_output_enable = i2c_enable;

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			ctrl_q <= CTRL_RESET;
		else if (ctrl_wr && i2c_enable)
			ctrl_q <= ctrl_wdata;
	end

	// Switching misbehaves until the gate has been set once; held off
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			gate_ever_set <= 1'b0;
		else if (ctrl_q.interface_gate_enable)
			gate_ever_set <= 1'b1;
	end

	assign charge_active = ctrl_q.interface_gate_enable &&
		ctrl_q.charge_enable;
	assign charging = charge_active && !battery_full_flag;
	assign low_allowed = gate_ever_set && !backup_mode &&
		(ctrl_q.battery_low_detect_enable || charging);

	always_comb
	begin
		next_state = state;
		case (state)
			ST_NORMAL:
				if (gate_ever_set && det.below_switchover)
					next_state = ST_BACKUP;
				else if (per_exp)
					next_state = ST_SAMPLE;
			ST_SAMPLE:
				if (gate_ever_set && det.below_switchover)
					next_state = ST_BACKUP;
				else if (win_exp)
					next_state = ST_NORMAL;
			ST_BACKUP:
				if (per_exp && !ctrl_q.stop)
					next_state = ST_BACKUP_CHECK;
			ST_BACKUP_CHECK:
				if (win_exp)
					next_state = det.below_switchover ?
						ST_BACKUP : ST_NORMAL;
			default:
				next_state = ST_NORMAL;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			state <= ST_NORMAL;
		else
			state <= next_state;
	end

	// Short open time holds until supply clears the reset threshold
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			returned <= 1'b0;
		else if (state == ST_BACKUP_CHECK && next_state == ST_NORMAL)
			returned <= 1'b1;
		else if (!backup_mode && !det.below_reset)
			returned <= 1'b0;
	end

	// Poll period: 1 s in normal mode, 31.25 ms in backup
	assign next_backup = (next_state == ST_BACKUP) ||
		(next_state == ST_BACKUP_CHECK);
	assign per_load = per_exp || per_idle || (next_backup != backup_mode);
	assign per_value = next_backup ? CNT_W'(BACKUP_POLL_CYC)
		: CNT_W'(BAT_POLL_CYC);

	interval_counter #(
		.W          (CNT_W)
	) u_period (
		.ref_clk    (ref_clk),
		.rst        (rst),
		.load       (per_load),
		.load_value (per_value),
		.count      (per_count),
		.expired    (per_exp),
		.idle       (per_idle)
	);

	assign win_load = (next_state != state) &&
		(next_state == ST_SAMPLE || next_state == ST_BACKUP_CHECK);
	assign win_value = (next_state == ST_SAMPLE) ?
		off_time(ctrl_q.sample_time_sel, returned)
		: DET_WINDOW_CYC;

	interval_counter #(
		.W          (CNT_W)
	) u_window (
		.ref_clk    (ref_clk),
		.rst        (rst),
		.load       (win_load),
		.load_value (win_value),
		.count      (win_count),
		.expired    (win_exp),
		.idle       ()
	);

	// A sample cut short by backup entry gives no result
	assign sample_done = (state == ST_SAMPLE) && (next_state == ST_NORMAL);

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			battery_full_flag <= 1'b0;
			bat_low_now       <= 1'b0;
		end
		else if (sample_done)
		begin
			battery_full_flag <= (ctrl_q.full_level_sel != FULL_OFF) &&
				det.above_full;
			bat_low_now <= det.below_low;
		end
	end

	// Detection set wins over a clearing write in the same cycle
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			battery_low_flag <= 1'b0;
		else if (sample_done && low_allowed && det.below_low)
			battery_low_flag <= 1'b1;
		else if (low_flag_wr && !low_flag_wdata && i2c_enable)
			battery_low_flag <= 1'b0;
	end

	// Both switches open while sampling; charge only when permitted
	assign supply_switch_on = (state == ST_NORMAL);
	assign charge_switch_on = (state == ST_NORMAL) && charging &&
		!bat_low_now;
	assign reset_detect_enable   = !backup_mode;
	assign supply_detect_enable  = (state != ST_BACKUP);
	assign battery_detect_enable = (state == ST_SAMPLE);
	assign full_level_code       = ctrl_q.full_level_sel;

	a_gate_blocks_bus: assert property (
		ctrl_q.interface_gate_enable && det.below_reset
		|-> !i2c_enable && !clock_output_enable)
		else $error("bus open below reset with gate set");

	a_gate_off_bus: assert property (
		!ctrl_q.interface_gate_enable && !backup_mode
		|-> i2c_enable && !charge_switch_on)
		else $error("gate off but bus closed or charging");

	a_locked_write: assert property (
		ctrl_wr && !i2c_enable |=> $stable(ctrl_q))
		else $error("control written while bus locked");

	a_backup_entry: assert property (
		!backup_mode && gate_ever_set && det.below_switchover
		|=> backup_mode)
		else $error("no backup entry on supply drop");

	// Window was loaded from the fields as they stood one cycle earlier
	a_open_time_sel: assert property (
		$rose(state == ST_SAMPLE)
		|-> win_count == off_time($past(ctrl_q.sample_time_sel),
			$past(returned)))
		else $error("wrong supply switch open time");

	a_backup_poll: assert property (
		$rose(backup_mode) |-> per_count == CNT_W'(BACKUP_POLL_CYC))
		else $error("backup poll period wrong");

	a_sample_sw_open: assert property (
		state == ST_SAMPLE
		|-> !supply_switch_on && !charge_switch_on && battery_detect_enable)
		else $error("switch closed during battery sample");

	a_no_charge: assert property (
		!ctrl_q.charge_enable |-> !charge_switch_on)
		else $error("charge switch on with charge disabled");

	a_full_off: assert property (
		sample_done && ctrl_q.full_level_sel == FULL_OFF
		|=> !battery_full_flag)
		else $error("full flag set with detection off");

	a_low_sticky: assert property (
		sample_done && low_allowed && det.below_low
		|=> battery_low_flag [*2])
		else $error("low flag not set or not held");

	a_stop_holds: assert property (
		state == ST_BACKUP && ctrl_q.stop |=> state == ST_BACKUP)
		else $error("backup poll ran with stop set");

	a_backup_pins: assert property (
		backup_mode |-> !i2c_enable && !clock_output_enable &&
			!battery_detect_enable)
		else $error("bus or battery detect on in backup");

	a_reset_vals: assert property (
		$past(rst) |-> ctrl_q == CTRL_RESET && state == ST_NORMAL)
		else $error("control fields not at defaults");

	c_backup_enter: cover property ($rose(backup_mode));
	c_backup_return: cover property (
		state == ST_BACKUP_CHECK ##1 state == ST_NORMAL);
	c_sample_done: cover property (sample_done);
	c_low_set: cover property ($rose(battery_low_flag));

endmodule

// ---- design/battery_switch_pkg.sv ----
/*
 * Constants, types and timing figures shared by the battery backup
 * switchover controller and its interval counter.
 * Assumes a single 100 MHz reference clock and analog comparators outside.
 */
// Summary of operation
// - Gate enable 1 blocks bus below reset
// - Gate enable 0 keeps bus, charge off
// - Setting gate below reset locks bus immediately
// - Normal mode watches switchover, enters backup
// - Supply switch opens periodically for measurement
// - Open time per sample-time field, 2ms after return
// - Backup mode polls supply every 31.25 ms
// - Battery detectors once per second, switches open
// - Charge enable 0 keeps charge switch open
// - Charge switch follows full and low detectors
// - Full level select codes, 11 means off
// - Full flag reflects last second's detection
// - Sticky low flag, host clears by zero
// - Low detect scope set by detect enable
// - No low detection in backup mode
// - Stop bit suspends backup supply polling
// - Charge enable 1 gives automatic switch control
// - Backup mode turns bus and clock output off
package battery_switch_pkg;

	localparam int CLK_PERIOD_NS    = 10;
	localparam int T_OFF_2MS_NS     = 2_000_000;
	localparam int T_OFF_16MS_NS    = 16_000_000;
	localparam int T_OFF_128MS_NS   = 128_000_000;
	localparam int T_OFF_256MS_NS   = 256_000_000;
	localparam int T_BACKUP_POLL_NS = 31_250_000;
	localparam int T_BAT_POLL_NS    = 1_000_000_000;
	// Comparator settle plus two synchroniser stages
	localparam int T_DET_WINDOW_NS  = 40;
	localparam int CNT_W            = 32;
	localparam logic [CNT_W-1:0] DET_WINDOW_CYC =
		CNT_W'(T_DET_WINDOW_NS / CLK_PERIOD_NS);

	localparam logic [1:0] SMP_2MS   = 2'h0;
	localparam logic [1:0] SMP_16MS  = 2'h1;
	localparam logic [1:0] SMP_128MS = 2'h2;
	localparam logic [1:0] SMP_256MS = 2'h3;

	localparam logic [1:0] FULL_3V02 = 2'h0;
	localparam logic [1:0] FULL_3V08 = 2'h1;
	localparam logic [1:0] FULL_2V92 = 2'h2;
	localparam logic [1:0] FULL_OFF  = 2'h3;

	typedef struct packed {
		logic [1:0] sample_time_sel;
		logic       charge_enable;
		logic       interface_gate_enable;
		logic       battery_low_detect_enable;
		logic       stop;
		logic [1:0] full_level_sel;
	} ctrl_s;

	localparam ctrl_s CTRL_RESET = '{
		sample_time_sel:           SMP_2MS,
		charge_enable:             1'b0,
		interface_gate_enable:     1'b0,
		battery_low_detect_enable: 1'b0,
		stop:                      1'b0,
		full_level_sel:            FULL_3V02
	};

	// Comparator results, asynchronous to ref_clk
	typedef struct packed {
		logic below_reset;
		logic below_switchover;
		logic above_full;
		logic below_low;
	} det_s;

	localparam int DET_W = $bits(det_s);

	typedef enum logic [1:0] {
		ST_NORMAL,
		ST_SAMPLE,
		ST_BACKUP,
		ST_BACKUP_CHECK
	} mode_e;

endpackage

// ---- design/interval_counter.sv ----
/*
 * Loadable down counter used for poll periods and sample windows.
 * Assumes load and load_value come from logic on ref_clk.
 */
`timescale 1ns/100ps
module interval_counter
	import battery_switch_pkg::*;
#(
	parameter int W = CNT_W
)(
	input  wire logic         ref_clk,
	input  wire logic         rst,
	input  wire logic         load,
	input  wire logic [W-1:0] load_value,
	output logic      [W-1:0] count,
	output logic              expired,
	output logic              idle
);

	localparam logic [W-1:0] ONE = W'(1);

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			count <= '0;
		else if (load)
			count <= load_value;
		else if (count != '0)
			count <= count - ONE;
	end

	// Expiry flags the last cycle of the interval
	assign expired = (count == ONE);
	assign idle    = (count == '0);

endmodule

// ---- tb/battery_backup_switch_control_test.sv ----
/*
 * Self-checking bench for the switchover control block.
 * Assumes shortened timing parameters and a comparator model at det_async.
 */
`timescale 1ns/100ps
module battery_backup_switch_control_test;
	import battery_switch_pkg::*;
	localparam int BP = 200;
	localparam int BK = 60;
	localparam int OFF [4] = '{20, 30, 40, 50};
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	det_s lv = '0;
	det_s det;
	logic ctrl_wr = 1'b0;
	ctrl_s ctrl_wdata = CTRL_RESET;
	logic low_flag_wr = 1'b0;
	logic low_flag_wdata = 1'b1;
	ctrl_s ctrl_q;
	logic battery_full_flag, battery_low_flag, i2c_enable;
	logic clock_output_enable, supply_switch_on, charge_switch_on;
	logic backup_mode, supply_detect_enable, battery_detect_enable;
	logic reset_detect_enable;
	logic [1:0] full_level_code;
	int   bad_count = 0;
	int   num_checks = 0;
	int   seed = 6;

	always #5 ref_clk = ~ref_clk;

	battery_backup_switch_control #(.OFF_2MS_CYC(20), .OFF_16MS_CYC(30),
		.OFF_128MS_CYC(40), .OFF_256MS_CYC(50), .BACKUP_POLL_CYC(BK),
		.BAT_POLL_CYC(BP)) u_dut (
		.ref_clk(ref_clk), .rst(rst), .det_async(det), .ctrl_wr(ctrl_wr),
		.ctrl_wdata(ctrl_wdata), .low_flag_wr(low_flag_wr),
		.low_flag_wdata(low_flag_wdata), .ctrl_q(ctrl_q),
		.battery_full_flag(battery_full_flag),
		.battery_low_flag(battery_low_flag), .i2c_enable(i2c_enable),
		.clock_output_enable(clock_output_enable),
		.supply_switch_on(supply_switch_on),
		.charge_switch_on(charge_switch_on), .backup_mode(backup_mode),
		.reset_detect_enable(reset_detect_enable),
		.supply_detect_enable(supply_detect_enable),
		.battery_detect_enable(battery_detect_enable),
		.full_level_code(full_level_code));

	supply_model u_model (.ref_clk(ref_clk), .level(lv),
		.bat_meas(battery_detect_enable), .sup_meas(supply_detect_enable),
		.det(det));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic wr(input ctrl_s v);
		@(posedge ref_clk);
		ctrl_wr    <= 1'b1;
		ctrl_wdata <= v;
		@(posedge ref_clk);
		ctrl_wr <= 1'b0;
		#1;
	endtask

	task automatic lwr(input logic v);
		@(posedge ref_clk);
		low_flag_wr    <= 1'b1;
		low_flag_wdata <= v;
		@(posedge ref_clk);
		low_flag_wr <= 1'b0;
		#1;
	endtask

	// Level change plus synchroniser delay
	task automatic setlv(input det_s v);
		@(posedge ref_clk);
		lv <= v;
		cyc(4);
	endtask

	// 0 supply switch, 1 supply detect, else backup mode
	function automatic logic pick(input int w);
		case (w)
			0: return supply_switch_on;
			1: return supply_detect_enable;
			default: return backup_mode;
		endcase
	endfunction

	task automatic wait_v(input int w, input logic v, input int lim,
		output int t);
		t = 0;
		while (pick(w) !== v && t < lim)
		begin
			cyc(1);
			t++;
		end
		if (pick(w) !== v)
		begin
			bad_count++;
			$display("unexpected at %0t: wait limit reached", $time);
		end
	endtask

	task automatic open_time(output int n);
		int t;
		wait_v(0, 1'b0, BP + 100, t);
		check(battery_detect_enable, 1'b1);
		check(charge_switch_on, 1'b0);
		wait_v(0, 1'b1, 400, n);
	endtask

	task automatic conclude;
		$display("checks %0d, mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial
	begin
		#200000;
		bad_count++;
		conclude();
	end

	initial
	begin
		ctrl_s c;
		det_s  d;
		int    n;
		int    t;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		cyc(1);
		check(ctrl_q, CTRL_RESET);
		check({supply_switch_on, charge_switch_on, i2c_enable, backup_mode,
			battery_full_flag, battery_low_flag}, 6'h28);
		c = CTRL_RESET;
		c.interface_gate_enable = 1'b1;
		wr(c);
		d = '0;
		d.below_reset = 1'b1;
		setlv(d);
		check({i2c_enable, clock_output_enable}, 2'h0);
		wr(CTRL_RESET);
		check(ctrl_q, c);
		setlv('0);
		check(i2c_enable, 1'b1);
		wr(CTRL_RESET);
		setlv(d);
		check({i2c_enable, clock_output_enable}, 2'h3);
		wr(c);
		check(i2c_enable, 1'b0);
		setlv('0);
		$display("gate test done");
		c.charge_enable  = 1'b1;
		c.full_level_sel = FULL_OFF;
		wr(c);
		cyc(2);
		check(charge_switch_on, 1'b1);
		c.interface_gate_enable = 1'b0;
		wr(c);
		cyc(2);
		check(charge_switch_on, 1'b0);
		c.interface_gate_enable = 1'b1;
		c.charge_enable = 1'b0;
		wr(c);
		cyc(2);
		check(charge_switch_on, 1'b0);
		$display("charge test done");
		for (int i = 0; i < 4; i++)
		begin
			c.sample_time_sel = 2'(i);
			wr(c);
			open_time(n);
			open_time(n);
			check(n, OFF[i]);
		end
		$display("sample time test done");
		c.sample_time_sel = SMP_2MS;
		// Reset level must stay clear or the bus locks out the writes
		d = '0;
		for (int i = 0; i < 8; i++)
		begin
			c.full_level_sel = 2'(i);
			d.above_full = 1'($random(seed));
			wr(c);
			check(full_level_code, c.full_level_sel);
			setlv(d);
			open_time(n);
			check(battery_full_flag, (i % 4 != 3) && d.above_full);
		end
		$display("full flag test done");
		d = '0;
		d.below_low = 1'b1;
		setlv(d);
		open_time(n);
		check(battery_low_flag, 1'b0);
		c.battery_low_detect_enable = 1'b1;
		wr(c);
		open_time(n);
		open_time(n);
		check(battery_low_flag, 1'b1);
		setlv('0);
		lwr(1'b1);
		check(battery_low_flag, 1'b1);
		lwr(1'b0);
		check(battery_low_flag, 1'b0);
		$display("low flag test done");
		c.sample_time_sel = SMP_256MS;
		wr(c);
		d = '0;
		d.below_switchover = 1'b1;
		setlv(d);
		check({backup_mode, i2c_enable, clock_output_enable}, 3'h4);
		check(reset_detect_enable, 1'b0);
		// Low level raised only in backup; no sample sees it until the return to normal
		d.below_low = 1'b1;
		setlv(d);
		wait_v(1, 1'b1, BK + 20, t);
		check(battery_detect_enable, 1'b0);
		wait_v(1, 1'b0, 20, t);
		check(t, 4);
		wait_v(1, 1'b1, BK + 20, n);
		check(t + n >= BK && t + n <= BK + 5, 1'b1);
		check(battery_low_flag, 1'b0);
		d.below_switchover = 1'b0;
		d.below_reset = 1'b1;
		setlv(d);
		wait_v(2, 1'b0, BK + 20, t);
		check(backup_mode, 1'b0);
		open_time(n);
		check(n, OFF[0]);
		check(battery_low_flag, 1'b1);
		setlv('0);
		$display("backup test done");
		c.stop = 1'b1;
		wr(c);
		d = '0;
		d.below_switchover = 1'b1;
		setlv(d);
		n = 0;
		repeat (3 * BK)
		begin
			cyc(1);
			if (supply_detect_enable !== 1'b0)
				n++;
		end
		check(n, 0);
		setlv('0);
		cyc(2 * BK);
		check(backup_mode, 1'b1);
		$display("stop test done");
		// Second power-on mid-run; host then rewrites with stop clear
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		cyc(1);
		check(ctrl_q, CTRL_RESET);
		check(backup_mode, 1'b0);
		c.stop = 1'b0;
		wr(c);
		check(ctrl_q, c);
		$display("reset test done");
		conclude();
	end
endmodule

// ---- tb/supply_model.sv ----
/*
 * Far side of the switchover block: supply and battery comparators.
 * Assumes the bench sets the analog levels; comparators that are not
 * powered give a level that changes every cycle.
 */
`timescale 1ns/100ps
module supply_model
	import battery_switch_pkg::*;
(
	input  wire logic ref_clk,
	input  wire det_s level,
	input  wire logic bat_meas,
	input  wire logic sup_meas,
	output det_s      det
);
	logic junk = 1'b0;

	always @(posedge ref_clk)
		junk <= ~junk;

	// Reset comparator always runs; others only while measuring
	always_comb
	begin
		det.below_reset      = level.below_reset;
		det.below_switchover = sup_meas ? level.below_switchover : junk;
		det.above_full       = bat_meas ? level.above_full : junk;
		det.below_low        = bat_meas ? level.below_low : ~junk;
	end
endmodule
